// ---- src/hlm_pkg.sv ----
// package: register map, field layout, reset values and modes of the loop and mode control bank
package hlm_pkg;
   // ---------------------------------------------
   // register offsets
   // ---------------------------------------------
   localparam logic [7:0] ADDR_LOCK_AND_FAULT_LIMITS   = 8'h17;
   localparam logic [7:0] ADDR_TRACK_PROP_COEFF_HIGH   = 8'h1C;
   localparam logic [7:0] ADDR_TRACK_PROP_COEFF_LOW    = 8'h1D;
   localparam logic [7:0] ADDR_TRACK_INTEG_COEFF_HIGH  = 8'h1E;
   localparam logic [7:0] ADDR_TRACK_INTEG_COEFF_LOW   = 8'h1F;
   localparam logic [7:0] ADDR_BRAKE_AND_PAUSE         = 8'h20;
   localparam logic [7:0] ADDR_OPERATION_CONTROL       = 8'h22;
   localparam logic [7:0] ADDR_OVERRIDE_DRIVE_LEVEL    = 8'h23;
   // ---------------------------------------------
   // reset values
   // ---------------------------------------------
   localparam logic [5:0] RST_LOCK_ERROR_LIMIT         = 6'h20;
   localparam logic [1:0] RST_BACKEMF_FAULT_THRESHOLD  = 2'h1;
   localparam logic [7:0] RST_TRACK_PROP_HIGH          = 8'h0E;
   localparam logic [7:0] RST_TRACK_PROP_LOW           = 8'h20;
   localparam logic [7:0] RST_TRACK_INTEG_HIGH         = 8'h03;
   localparam logic [7:0] RST_TRACK_INTEG_LOW          = 8'h20;
   localparam logic [2:0] RST_BRAKE_CUTOFF_THRESHOLD   = 3'h4;
   localparam logic [3:0] RST_TRACKING_PAUSE_THRESHOLD = 4'h3;
   localparam logic [7:0] RST_DIRECT_DRIVE_LEVEL       = 8'h00;
   // ---------------------------------------------
   // field positions
   // ---------------------------------------------
   localparam int LOCK_LIM_LSB   = 2;
   localparam int LOCK_LIM_MSB   = 7;
   localparam int FAULT_LIM_MSB  = 1;
   localparam int BRAKE_LIM_LSB  = 4;
   localparam int BRAKE_LIM_MSB  = 6;
   localparam int PAUSE_LIM_MSB  = 3;
   localparam int GO_BIT         = 4;
   localparam int STANDBY_BIT    = 3;
   localparam int MODE_MSB       = 2;
   // ---------------------------------------------
   // back-emf fault thresholds in microvolts
   // ---------------------------------------------
   localparam logic [15:0] BEMF_THR_CODE1_UV = 16'h1324;  // 4.9 mV
   localparam logic [15:0] BEMF_THR_CODE2_UV = 16'h6CFC;  // 27.9 mV
   localparam logic [15:0] BEMF_THR_CODE3_UV = 16'hC2EC;  // 49.9 mV
   // ---------------------------------------------
   // drive scaling codes
   // ---------------------------------------------
   localparam logic [7:0] DRIVE_NEG_FULL  = 8'h80;
   localparam logic [7:0] DRIVE_NEG_CLAMP = 8'h81;
   localparam logic [7:0] DRIVE_ZERO      = 8'h00;
   // ---------------------------------------------
   // operation modes and device states
   // ---------------------------------------------
   typedef enum logic [2:0] {
      HLM_MODE_INACTIVE = 3'h0,
      HLM_MODE_DIRECT   = 3'h1,
      HLM_MODE_PWM      = 3'h2,
      HLM_MODE_REGTRIG  = 3'h3,
      HLM_MODE_EDGETRIG = 3'h4
   } hlm_mode_t;
   typedef enum logic [2:0] {
      HLM_ST_IDLE    = 3'b001,
      HLM_ST_PLAY    = 3'b010,
      HLM_ST_STANDBY = 3'b100
   } hlm_state_t;
endpackage

// ---- src/hlm_regs.sv ----
// module: loop and mode control register bank of the haptic driver
`timescale 1ns/100ps
module hlm_regs
   import hlm_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   output logic      [7:0]  reg_rdata,
   output logic             reg_hit,
   input  wire logic        accel_enable,
   input  wire logic [15:0] backemf_uv,
   input  wire logic [13:0] track_error,
   input  wire logic        playback_done,
   input  wire logic        braking,
   input  wire logic [2:0]  brake_level,
   input  wire logic [3:0]  backemf_level,
   output logic             backemf_fault,
   output logic             freq_locked,
   output logic      [15:0] track_prop_coeff,
   output logic      [15:0] track_integ_coeff,
   output logic             brake_drive_stop,
   output logic             tracking_paused,
   output hlm_mode_t        active_mode,
   output hlm_state_t       dev_state,
   output logic signed [8:0] drive_scale
);
   // ---------------------------------------------
   // register storage
   // ---------------------------------------------
   logic [5:0]  lock_error_limit;
   logic [1:0]  backemf_fault_threshold;
   logic [7:0]  track_prop_high;
   logic [7:0]  track_prop_low;
   logic [7:0]  track_integ_high;
   logic [7:0]  track_integ_low;
   logic [2:0]  brake_cutoff_threshold;
   logic [3:0]  tracking_pause_threshold;
   logic        playback_go;
   logic        standby_after;
   logic [2:0]  mode_field;
   logic [7:0]  direct_drive_level;

   logic [5:0]  next_lock_error_limit;
   logic [1:0]  next_backemf_fault_threshold;
   logic [7:0]  next_track_prop_high;
   logic [7:0]  next_track_prop_low;
   logic [7:0]  next_track_integ_high;
   logic [7:0]  next_track_integ_low;
   logic [2:0]  next_brake_cutoff_threshold;
   logic [3:0]  next_tracking_pause_threshold;
   logic        next_playback_go;
   logic        next_standby_after;
   logic [2:0]  next_mode_field;
   logic [7:0]  next_direct_drive_level;
   logic [7:0]  next_reg_rdata;
   logic        next_reg_hit;

   function automatic logic addr_mapped(input logic [7:0] a);
      case (a)
         ADDR_LOCK_AND_FAULT_LIMITS, ADDR_TRACK_PROP_COEFF_HIGH,
         ADDR_TRACK_PROP_COEFF_LOW, ADDR_TRACK_INTEG_COEFF_HIGH,
         ADDR_TRACK_INTEG_COEFF_LOW, ADDR_BRAKE_AND_PAUSE,
         ADDR_OPERATION_CONTROL, ADDR_OVERRIDE_DRIVE_LEVEL: addr_mapped = 1'b1;
         default: addr_mapped = 1'b0;
      endcase
   endfunction

   always_comb begin
      next_lock_error_limit         = lock_error_limit;
      next_backemf_fault_threshold  = backemf_fault_threshold;
      next_track_prop_high          = track_prop_high;
      next_track_prop_low           = track_prop_low;
      next_track_integ_high         = track_integ_high;
      next_track_integ_low          = track_integ_low;
      next_brake_cutoff_threshold   = brake_cutoff_threshold;
      next_tracking_pause_threshold = tracking_pause_threshold;
      next_playback_go              = playback_go;
      next_standby_after            = standby_after;
      next_mode_field               = mode_field;
      next_direct_drive_level       = direct_drive_level;
      if (reg_wr) begin
         case (reg_addr)
            ADDR_LOCK_AND_FAULT_LIMITS: begin
               next_lock_error_limit        = reg_wdata[LOCK_LIM_MSB:LOCK_LIM_LSB];
               next_backemf_fault_threshold = reg_wdata[FAULT_LIM_MSB:0];
            end
            ADDR_TRACK_PROP_COEFF_HIGH:  next_track_prop_high  = reg_wdata;
            ADDR_TRACK_PROP_COEFF_LOW:   next_track_prop_low   = reg_wdata;
            ADDR_TRACK_INTEG_COEFF_HIGH: next_track_integ_high = reg_wdata;
            ADDR_TRACK_INTEG_COEFF_LOW:  next_track_integ_low  = reg_wdata;
            ADDR_BRAKE_AND_PAUSE: begin
               next_brake_cutoff_threshold   = reg_wdata[BRAKE_LIM_MSB:BRAKE_LIM_LSB];
               next_tracking_pause_threshold = reg_wdata[PAUSE_LIM_MSB:0];
            end
            ADDR_OPERATION_CONTROL: begin
               next_playback_go   = reg_wdata[GO_BIT];
               next_standby_after = reg_wdata[STANDBY_BIT];
               next_mode_field    = reg_wdata[MODE_MSB:0];
            end
            ADDR_OVERRIDE_DRIVE_LEVEL:   next_direct_drive_level = reg_wdata;
            default: ;
         endcase
      end
      // playback finished: go bit drops unless software writes it this cycle
      if (playback_done && dev_state == HLM_ST_PLAY &&
          !(reg_wr && reg_addr == ADDR_OPERATION_CONTROL))
         next_playback_go = 1'b0;
      next_reg_hit   = (reg_wr || reg_rd) && addr_mapped(reg_addr);
      next_reg_rdata = 8'h00;
      if (reg_rd) begin
         case (reg_addr)
            ADDR_LOCK_AND_FAULT_LIMITS:  next_reg_rdata = {lock_error_limit,
                                                           backemf_fault_threshold};
            ADDR_TRACK_PROP_COEFF_HIGH:  next_reg_rdata = track_prop_high;
            ADDR_TRACK_PROP_COEFF_LOW:   next_reg_rdata = track_prop_low;
            ADDR_TRACK_INTEG_COEFF_HIGH: next_reg_rdata = track_integ_high;
            ADDR_TRACK_INTEG_COEFF_LOW:  next_reg_rdata = track_integ_low;
            ADDR_BRAKE_AND_PAUSE:        next_reg_rdata = {1'b0, brake_cutoff_threshold,
                                                           tracking_pause_threshold};
            ADDR_OPERATION_CONTROL:      next_reg_rdata = {3'b000, playback_go,
                                                           standby_after, mode_field};
            ADDR_OVERRIDE_DRIVE_LEVEL:   next_reg_rdata = direct_drive_level;
            default:                     next_reg_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         lock_error_limit         <= RST_LOCK_ERROR_LIMIT;
         backemf_fault_threshold  <= RST_BACKEMF_FAULT_THRESHOLD;
         track_prop_high          <= RST_TRACK_PROP_HIGH;
         track_prop_low           <= RST_TRACK_PROP_LOW;
         track_integ_high         <= RST_TRACK_INTEG_HIGH;
         track_integ_low          <= RST_TRACK_INTEG_LOW;
         brake_cutoff_threshold   <= RST_BRAKE_CUTOFF_THRESHOLD;
         tracking_pause_threshold <= RST_TRACKING_PAUSE_THRESHOLD;
         playback_go              <= 1'b0;
         standby_after            <= 1'b0;
         mode_field               <= 3'h0;
         direct_drive_level       <= RST_DIRECT_DRIVE_LEVEL;
         reg_rdata                <= 8'h00;
         reg_hit                  <= 1'b0;
      end else begin
         lock_error_limit         <= next_lock_error_limit;
         backemf_fault_threshold  <= next_backemf_fault_threshold;
         track_prop_high          <= next_track_prop_high;
         track_prop_low           <= next_track_prop_low;
         track_integ_high         <= next_track_integ_high;
         track_integ_low          <= next_track_integ_low;
         brake_cutoff_threshold   <= next_brake_cutoff_threshold;
         tracking_pause_threshold <= next_tracking_pause_threshold;
         playback_go              <= next_playback_go;
         standby_after            <= next_standby_after;
         mode_field               <= next_mode_field;
         direct_drive_level       <= next_direct_drive_level;
         reg_rdata                <= next_reg_rdata;
         reg_hit                  <= next_reg_hit;
      end
   end

   // ---------------------------------------------
   // derived control outputs
   // ---------------------------------------------
   logic             next_backemf_fault;
   logic             next_freq_locked;
   logic             next_brake_drive_stop;
   logic             next_tracking_paused;
   hlm_mode_t        next_active_mode;
   hlm_state_t       next_dev_state;
   logic signed [8:0] next_drive_scale;
   logic [15:0]      fault_thr;

   always_comb begin
      case (backemf_fault_threshold)
         2'h1:    fault_thr = BEMF_THR_CODE1_UV;
         2'h2:    fault_thr = BEMF_THR_CODE2_UV;
         2'h3:    fault_thr = BEMF_THR_CODE3_UV;
         default: fault_thr = 16'h0000;
      endcase
      next_backemf_fault = (backemf_fault_threshold != 2'h0) && (backemf_uv < fault_thr);
      next_freq_locked = track_error < {6'h00, lock_error_limit, 2'b00};
      next_brake_drive_stop = braking && (brake_level >= brake_cutoff_threshold);
      next_tracking_paused = backemf_level <= tracking_pause_threshold;
      case (mode_field)
         3'h1:    next_active_mode = HLM_MODE_DIRECT;
         3'h2:    next_active_mode = HLM_MODE_PWM;
         3'h3:    next_active_mode = HLM_MODE_REGTRIG;
         3'h4:    next_active_mode = HLM_MODE_EDGETRIG;
         default: next_active_mode = HLM_MODE_INACTIVE;
      endcase
      next_drive_scale = 9'sh000;
      if (next_active_mode == HLM_MODE_DIRECT) begin
         if (!direct_drive_level[7])
            next_drive_scale = $signed({1'b0, direct_drive_level});
         else if (accel_enable)
            next_drive_scale = 9'sh000;
         else if (direct_drive_level == DRIVE_NEG_FULL)
            next_drive_scale = $signed({1'b1, DRIVE_NEG_CLAMP});
         else
            next_drive_scale = $signed({1'b1, direct_drive_level});
      end
      next_dev_state = dev_state;
      case (dev_state)
         HLM_ST_IDLE, HLM_ST_STANDBY:
            if (playback_go) next_dev_state = HLM_ST_PLAY;
         HLM_ST_PLAY:
            if (!playback_go) next_dev_state = HLM_ST_IDLE;
            else if (playback_done)
               next_dev_state = standby_after ? HLM_ST_STANDBY : HLM_ST_IDLE;
         default: next_dev_state = HLM_ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         backemf_fault    <= 1'b0;
         freq_locked      <= 1'b0;
         brake_drive_stop <= 1'b0;
         tracking_paused  <= 1'b0;
         active_mode      <= HLM_MODE_INACTIVE;
         dev_state        <= HLM_ST_IDLE;
         drive_scale      <= 9'sh000;
      end else begin
         backemf_fault    <= next_backemf_fault;
         freq_locked      <= next_freq_locked;
         brake_drive_stop <= next_brake_drive_stop;
         tracking_paused  <= next_tracking_paused;
         active_mode      <= next_active_mode;
         dev_state        <= next_dev_state;
         drive_scale      <= next_drive_scale;
      end
   end

   assign track_prop_coeff  = {track_prop_high, track_prop_low};
   assign track_integ_coeff = {track_integ_high, track_integ_low};

   // ---------------------------------------------
   // assertions
   // ---------------------------------------------
   sequence s_play;
      dev_state == HLM_ST_PLAY && playback_go && playback_done;
   endsequence
   property p_fault;
      @(posedge ref_clk) disable iff (!rst_n)
      (backemf_fault_threshold == 2'h0) |=> !backemf_fault;
   endproperty
   a_fault: assert property (p_fault) else $error("fault raised while disabled");
   property p_lock;
      @(posedge ref_clk) disable iff (!rst_n)
      (track_error >= {6'h00, lock_error_limit, 2'b00}) |=> !freq_locked;
   endproperty
   a_lock: assert property (p_lock) else $error("lock with large error");
   property p_prop;
      @(posedge ref_clk) disable iff (!rst_n)
      (reg_wr && reg_addr == ADDR_TRACK_PROP_COEFF_LOW) |=>
         track_prop_coeff[7:0] == $past(reg_wdata);
   endproperty
   a_prop: assert property (p_prop) else $error("prop low byte not stored");
   property p_integ;
      @(posedge ref_clk) disable iff (!rst_n)
      (reg_wr && reg_addr == ADDR_TRACK_INTEG_COEFF_HIGH) |=>
         track_integ_coeff[15:8] == $past(reg_wdata);
   endproperty
   a_integ: assert property (p_integ) else $error("integ high byte not stored");
   property p_brake;
      @(posedge ref_clk) disable iff (!rst_n)
      !braking |=> !brake_drive_stop;
   endproperty
   a_brake: assert property (p_brake) else $error("stop without braking");
   property p_stop;
      @(posedge ref_clk) disable iff (!rst_n)
      (dev_state == HLM_ST_PLAY && !playback_go) |=> dev_state == HLM_ST_IDLE;
   endproperty
   a_stop: assert property (p_stop) else $error("playback not stopped");
   property p_post;
      @(posedge ref_clk) disable iff (!rst_n)
      s_play |=> dev_state == ($past(standby_after) ? HLM_ST_STANDBY : HLM_ST_IDLE) [*1];
   endproperty
   a_post: assert property (p_post) else $error("wrong post-playback state");
   property p_clamp;
      @(posedge ref_clk) disable iff (!rst_n)
      (accel_enable && mode_field == 3'h1 && direct_drive_level[7]) |=> drive_scale == 9'sh000;
   endproperty
   a_clamp: assert property (p_clamp) else $error("negative code not clamped");
endmodule

// ---- testbench/hlm_regs_tb.sv ----
// testbench: register access and derived control outputs of the loop and mode bank
`timescale 1ns/100ps
module hlm_regs_tb;
   import hlm_pkg::*;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic              ref_clk, rst_n, reg_wr, reg_rd, reg_hit, accel_enable;
   logic              playback_done, braking, backemf_fault, freq_locked;
   logic              brake_drive_stop, tracking_paused;
   logic       [7:0]  reg_addr, reg_wdata, reg_rdata;
   logic       [15:0] backemf_uv, track_prop_coeff, track_integ_coeff;
   logic       [13:0] track_error;
   logic       [2:0]  brake_level;
   logic       [3:0]  backemf_level;
   hlm_mode_t         active_mode;
   hlm_state_t        dev_state;
   logic signed [8:0] drive_scale;
   logic       [8:0]  exp9;
   int                failures = 0;
   int                n_checks = 0;
   logic       [7:0]  addrs [8] = '{8'h17, 8'h1C, 8'h1D, 8'h1E, 8'h1F, 8'h20, 8'h22, 8'h23};
   logic       [7:0]  rstv  [8] = '{8'h81, 8'h0E, 8'h20, 8'h03, 8'h20, 8'h43, 8'h00, 8'h00};
   logic       [15:0] thr   [4] = '{16'h0000, 16'h1324, 16'h6CFC, 16'hC2EC};
   logic       [7:0]  codes [6] = '{8'h7F, 8'h01, 8'h00, 8'hFF, 8'h81, 8'h80};
   logic       [8:0]  sgn   [6] = '{9'h07F, 9'h001, 9'h000, 9'h1FF, 9'h181, 9'h181};
   logic       [5:0]  lims  [2] = '{6'h05, 6'h3F};
   // ----------------------------------------
   // design under test
   // ----------------------------------------
   hlm_regs hlm_regs_inst (
      .ref_clk(ref_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
      .accel_enable(accel_enable), .backemf_uv(backemf_uv), .track_error(track_error),
      .playback_done(playback_done), .braking(braking), .brake_level(brake_level),
      .backemf_level(backemf_level), .backemf_fault(backemf_fault), .freq_locked(freq_locked),
      .track_prop_coeff(track_prop_coeff), .track_integ_coeff(track_integ_coeff),
      .brake_drive_stop(brake_drive_stop), .tracking_paused(tracking_paused),
      .active_mode(active_mode), .dev_state(dev_state), .drive_scale(drive_scale)
   );
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_rd = 1'b0;
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(posedge ref_clk);
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic hit);
      reg_wr = 1'b0;
      reg_rd = 1'b1;
      reg_addr = a;
      @(posedge ref_clk);
      #1;
      check("reg_rdata", {8'h00, reg_rdata}, {8'h00, exp});
      check("reg_hit", {15'h0000, reg_hit}, {15'h0000, hit});
   endtask
   task automatic settle();
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
   endtask
   task automatic chk_bp(input logic b, input logic [2:0] bl, input logic [3:0] el,
                         input logic es, input logic ep);
      braking = b;
      brake_level = bl;
      backemf_level = el;
      settle();
      check("brake_drive_stop", {15'h0000, brake_drive_stop}, {15'h0000, es});
      check("tracking_paused", {15'h0000, tracking_paused}, {15'h0000, ep});
   endtask
   task automatic pulse_done();
      playback_done = 1'b1;
      @(posedge ref_clk);
      #1 playback_done = 1'b0;
      settle();
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // ----------------------------------------
   // clock and watchdog
   // ----------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   initial begin
      #20000;
      failures++;
      tally_and_finish();
   end
   // ----------------------------------------
   // test sequence
   // ----------------------------------------
   initial begin
      rst_n = 1'b0;
      {reg_wr, reg_rd, accel_enable, playback_done, braking} = 5'h00;
      {reg_addr, reg_wdata, backemf_uv, track_error} = 46'h0;
      {brake_level, backemf_level} = 7'h00;
      repeat (12) @(posedge ref_clk);
      #1 rst_n = 1'b1;
      for (int i = 0; i < 8; i++) rd(addrs[i], rstv[i], 1'b1);
      rd(8'h21, 8'h00, 1'b0);
      check("state", {13'h0, dev_state}, {13'h0, HLM_ST_IDLE});
      check("prop", track_prop_coeff, 16'h0E20);
      check("integ", track_integ_coeff, 16'h0320);
      wr(8'h1C, 8'hA5);
      wr(8'h1D, 8'h5A);
      wr(8'h1E, 8'hC3);
      wr(8'h1F, 8'h3C);
      wr(8'h21, 8'hFF);
      rd(8'h1C, 8'hA5, 1'b1);
      rd(8'h1F, 8'h3C, 1'b1);
      rd(8'h21, 8'h00, 1'b0);
      settle();
      check("prop", track_prop_coeff, 16'hA55A);
      check("integ", track_integ_coeff, 16'hC33C);
      for (int c = 0; c < 4; c++) begin
         wr(8'h17, {6'h20, c[1:0]});
         backemf_uv = (c == 0) ? 16'h0000 : thr[c] - 16'h0001;
         settle();
         check("fault_below", {15'h0, backemf_fault}, {15'h0, c != 0});
         backemf_uv = thr[c];
         settle();
         check("fault_at", {15'h0, backemf_fault}, 16'h0000);
      end
      for (int i = 0; i < 2; i++) begin
         wr(8'h17, {lims[i], 2'h0});
         track_error = {6'h00, lims[i], 2'h0} - 14'h0001;
         settle();
         check("locked", {15'h0, freq_locked}, 16'h0001);
         track_error = {6'h00, lims[i], 2'h0};
         settle();
         check("unlocked", {15'h0, freq_locked}, 16'h0000);
      end
      chk_bp(1'b1, 3'h3, 4'h3, 1'b0, 1'b1);
      chk_bp(1'b1, 3'h4, 4'h4, 1'b1, 1'b0);
      chk_bp(1'b0, 3'h7, 4'h4, 1'b0, 1'b0);
      wr(8'h20, 8'hA5);
      rd(8'h20, 8'h25, 1'b1);
      chk_bp(1'b1, 3'h2, 4'h5, 1'b1, 1'b1);
      chk_bp(1'b1, 3'h1, 4'h6, 1'b0, 1'b0);
      for (int m = 0; m < 8; m++) begin
         wr(8'h22, {5'b11100, m[2:0]});
         rd(8'h22, {5'h00, m[2:0]}, 1'b1);
         settle();
         check("mode", {13'h0, active_mode}, (m < 5) ? m[15:0] : 16'h0000);
      end
      wr(8'h22, 8'h01);
      for (int a = 0; a < 2; a++) begin
         accel_enable = a[0];
         for (int i = 0; i < 6; i++) begin
            wr(8'h23, codes[i]);
            settle();
            exp9 = (a == 1 && codes[i][7]) ? 9'h000 : sgn[i];
            check("drive_scale", {7'h00, drive_scale}, {7'h00, exp9});
         end
      end
      wr(8'h23, 8'h7F);
      wr(8'h22, 8'h02);
      settle();
      check("drive_off", {7'h00, drive_scale}, 16'h0000);
      wr(8'h22, 8'h10);
      settle();
      check("state", {13'h0, dev_state}, {13'h0, HLM_ST_PLAY});
      wr(8'h22, 8'h00);
      settle();
      check("state", {13'h0, dev_state}, {13'h0, HLM_ST_IDLE});
      wr(8'h22, 8'h10);
      settle();
      pulse_done();
      check("state", {13'h0, dev_state}, {13'h0, HLM_ST_IDLE});
      wr(8'h22, 8'h18);
      settle();
      check("state", {13'h0, dev_state}, {13'h0, HLM_ST_PLAY});
      pulse_done();
      check("state", {13'h0, dev_state}, {13'h0, HLM_ST_STANDBY});
      rd(8'h22, 8'h08, 1'b1);
      settle();
      tally_and_finish();
   end
endmodule
